// ==== dv/spsb_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spsb_ctrl_model (
	input wire logic clk,
	input wire logic srq_n,
	input wire logic status_drive_n,
	input wire logic [7:0] status_byte,
	input wire logic [7:0] error_code,
	input wire logic [3:0] dly,
	output logic spe_active,
	output logic spe_done,
	output logic got,
	output logic [15:0] got_data
);
	initial begin
		{spe_active, spe_done, got, got_data} = 19'h0;
		forever begin
			@(negedge clk);
			if (!srq_n) begin
				spe_active = 1'b1;
				repeat (dly + 2) @(negedge clk);
				// a byte not driven shows inverted so it can never match
				got_data[15:8] = status_drive_n ? ~status_byte : status_byte;
				spe_done = 1'b1;
				@(negedge clk);
				{spe_active, spe_done} = 2'h0;
				got_data[7:0] = error_code;
				got = 1'b1;
				@(negedge clk);
				got = 1'b0;
			end
		end
	end
endmodule : spsb_ctrl_model
`default_nettype wire

// ==== dv/spsb_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module spsb_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic spe_active,
	input wire logic spe_done,
	input wire logic prog_error,
	input wire logic cmd_accept,
	input wire logic [7:0] status_byte,
	input wire logic status_drive_n,
	input wire logic srq_oe_n,
	input wire logic trig_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence s_flagged;
		status_byte[6:5] == 2'h3 && !srq_oe_n;
	endsequence
	sequence s_busy;
		!status_byte[4] && trig_out;
	endsequence
	////////////////////////////////////////////////////////////////////////
	// poll drive and status byte checks
	AST_DRIVE: assert property (spe_active |=> !status_drive_n)
		else $error("byte not driven");
	AST_UNUSED: assert property (status_byte[7] == 1'b0 && status_byte[2:0] == 3'h0)
		else $error("unused bit set");
	AST_SRQ: assert property (status_byte[6] == !srq_oe_n)
		else $error("srq mismatch");
	AST_REFUSE: assert property (status_byte[6] |-> !cmd_accept)
		else $error("command taken");
	AST_CLEAR: assert property (spe_done && !prog_error && !cmd_accept |=> status_byte[6:5] == 2'h0)
		else $error("flags kept");
	AST_ERR: assert property (prog_error |=> s_flagged)
		else $error("error not flagged");
	AST_RDY: assert property (cmd_accept |=> s_busy)
		else $error("ready kept");
	AST_TRIG: assert property (trig_out != status_byte[4])
		else $error("trigger mismatch");
endmodule : spsb_props
`default_nettype wire

// ==== dv/tb_serial_poll_status_byte.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_serial_poll_status_byte import spsb_pkg::*; ;
	logic clk, rstn, sa, sd, cv, hl, ca, ed, pe, bk, dn, so, soe, tr, rl, srq_n, got;
	spsb_cmd_t op;
	logic [6:0] loc;
	logic [7:0] pc, sb, ec;
	logic [3:0] mp, rm, dly;
	logic [31:0] rin, rout, seed, keep;
	logic [15:0] gd;
	logic [15:0] q[$];
	int errors, tests_run;
	// srq is open drain with a pull-up
	assign srq_n = soe ? 1'b1 : so;
	spsb_status_core i_spsb_status_core (.clk(clk), .rstn(rstn), .spe_active(sa),
		.spe_done(sd), .cmd_valid(cv), .cmd_op(op), .cmd_has_loc(hl), .cmd_loc(loc),
		.cmd_accept(ca), .exec_done(ed), .prog_error(pe), .prog_error_code(pc),
		.scan_breakpoint(bk), .modules_present(mp), .relay_state_in(rin), .status_byte(sb),
		.status_drive_n(dn), .srq_o(so), .srq_oe_n(soe), .trig_out(tr), .error_code(ec),
		.relay_state_out(rout), .relay_load_mask(rm), .relay_load(rl));
	spsb_ctrl_model i_spsb_ctrl_model (.clk(clk), .srq_n(srq_n), .status_drive_n(dn),
		.status_byte(sb), .error_code(ec), .dly(dly), .spe_active(sa), .spe_done(sd),
		.got(got), .got_data(gd));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic chk_poll(input logic [15:0] g, input logic [15:0] e);
		chk(g, e);
	endtask : chk_poll
	task automatic chk_relay(input logic [36:0] g, input logic [36:0] e);
		chk(g, e);
	endtask : chk_relay
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task automatic cmd(input spsb_cmd_t o, input logic h, input logic [6:0] l);
		int n;
		n = 0;
		@(negedge clk);
		op = o;
		{hl, loc, cv} = {h, l, 1'b1};
		#1;
		while (ca !== 1'b1 && n < 50) begin
			@(negedge clk);
			#1;
			n++;
		end
		if (ca !== 1'b1) begin
			errors++;
			close_out();
		end
		wt(1);
		cv = 1'b0;
		chk(sb[4], 1'b0);
	endtask : cmd
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge got) begin
		if (q.size() == 0)
			chk_poll(gd, 16'hxxxx);
		else
			chk_poll(gd, q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end
	initial begin
		{errors, tests_run} = 0;
		seed = 32'h66a3e9c6;
		{rstn, cv, hl, ed, pe, bk, loc, pc, mp, rin, dly} = {6'h00, 7'h00, 8'h00, 4'h3, 32'h0, 4'h1};
		op = CMD_OTHER;
		wt(20);
		rstn = 1'b1;
		wt(3);
		chk({rm, rout, sb}, {4'h3, 32'h0, 8'h10});
		seed = xs(seed);
		{rin, keep} = {seed, seed};
		cmd(CMD_SAVE, 1'b1, LOC_POWERUP);
		wt(1);
		chk({sb[4], tr}, 2'h2);
		{mp, rin} = {4'hf, ~keep};
		cmd(CMD_SAVE, 1'b0, 7'h00);
		cmd(CMD_RECALL, 1'b0, 7'h00);
		wt(1);
		chk_relay({rl, rm, rout}, {1'b1, 4'hf, ~keep});
		cmd(CMD_RECALL, 1'b1, LOC_POWERUP);
		wt(1);
		chk_relay({rl, rm, rout}, {1'b1, 4'h3, keep});
		cmd(CMD_SAVE, 1'b1, LOC_POWERUP);
		cmd(CMD_RECALL, 1'b1, LOC_POWERUP);
		wt(1);
		chk_relay({rl, rm, rout}, {1'b1, 4'hf, ~keep});
		$display("test save recall done");
		bk = 1'b1;
		q.push_back({8'h78, ERR_BAD_LOC});
		cmd(CMD_SAVE, 1'b1, 7'h65);
		@(negedge clk);
		cv = 1'b1;
		#1;
		chk(ca, 1'b0);
		wt(1);
		cv = 1'b0;
		wt(12);
		chk({soe, sb}, {1'b1, 8'h18});
		$display("test bad location done");
		seed = xs(seed);
		{pe, pc, dly} = {1'b1, seed[7:0], 4'hc};
		q.push_back({8'h78, seed[7:0]});
		wt(1);
		pe = 1'b0;
		wt(30);
		chk(sb, 8'h18);
		cmd(CMD_OTHER, 1'b0, 7'h00);
		wt(3);
		ed = 1'b1;
		wt(1);
		ed = 1'b0;
		wt(1);
		chk(sb[4], 1'b1);
		$display("test errors and execute done");
		rstn = 1'b0;
		wt(2);
		rstn = 1'b1;
		wt(3);
		chk({rm, rout, sb}, {4'hf, 32'h0, 8'h18});
		chk(q.size(), 0);
		$display("test second reset done");
		close_out();
	end
endmodule : tb_serial_poll_status_byte
bind spsb_status_core spsb_props i_spsb_props (.*);
`default_nettype wire

// ==== shared/spsb_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface spsb_mem_if #(
	parameter int AW = 7,
	parameter int W = 8
);
	logic we;
	logic re;
	logic [AW-1:0] waddr;
	logic [AW-1:0] raddr;
	logic [W-1:0] wdata;
	logic [W-1:0] rdata;
	logic rvalid;

	modport ctrl(output we, re, waddr, raddr, wdata, input rdata, rvalid);
	modport store(input we, re, waddr, raddr, wdata, output rdata, rvalid);
endinterface : spsb_mem_if
`default_nettype wire

// ==== shared/spsb_pkg.sv ====
package spsb_pkg;

	////////////////////////////////////////////////////////////////////////
	// status byte field positions (bit index 0 is the lsb)
	localparam int STB_BREAK_BIT = 3;
	localparam int STB_READY_BIT = 4;
	localparam int STB_ERR_BIT = 5;
	localparam int STB_SRQ_BIT = 6;
	localparam int STB_WIDTH = 8;

	////////////////////////////////////////////////////////////////////////
	// stored relay state locations
	localparam int LOC_WIDTH = 7;
	localparam logic [6:0] LOC_POWERUP = 7'h00;
	localparam logic [6:0] LOC_DEFAULT = 7'h64;
	localparam logic [6:0] LOC_MAX = 7'h64;
	localparam int NV_DEPTH = 101;

	////////////////////////////////////////////////////////////////////////
	// error codes and values after reset
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_BAD_LOC = 8'h01;
	localparam logic RST_READY = 1'b0;
	localparam logic RST_TRIG = 1'b1;
	localparam logic RST_DRIVE_N = 1'b1;

	typedef enum logic [1:0] {
		CMD_OTHER = 2'h0,
		CMD_SAVE = 2'h1,
		CMD_RECALL = 2'h2
	} spsb_cmd_t;

	typedef enum logic [5:0] {
		ST_BOOT_RD = 6'h01,
		ST_BOOT_WT = 6'h02,
		ST_IDLE = 6'h04,
		ST_EXEC = 6'h08,
		ST_RCL_WT = 6'h10,
		ST_FINISH = 6'h20
	} spsb_state_t;

	function automatic logic [7:0] spsb_build_stb(input logic brk, input logic rdy,
			input logic err, input logic srq);
		logic [7:0] b;
		b = 8'h00;
		b[STB_BREAK_BIT] = brk;
		b[STB_READY_BIT] = rdy;
		b[STB_ERR_BIT] = err;
		b[STB_SRQ_BIT] = srq;
		return b;
	endfunction : spsb_build_stb

endpackage : spsb_pkg

// ==== verilog/spsb_nv_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module spsb_nv_store #(
	parameter int DEPTH = 101,
	parameter int AW = 7,
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	spsb_mem_if.store m
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [DEPTH-1:0] valid;
		logic [W-1:0] rdata;
		logic rvalid;
	} spsb_store_t;

	spsb_store_t st_reg;
	spsb_store_t st_next;

	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
		$error("spsb_nv_store: depth does not fit the address width");
	end

	always_comb begin
		st_next = st_reg;
		if (m.we && (int'(m.waddr) < DEPTH)) begin
			st_next.mem[m.waddr] = m.wdata;
			st_next.valid[m.waddr] = 1'b1;
		end
		if (m.re) begin
			if (int'(m.raddr) < DEPTH) begin
				st_next.rdata = st_reg.mem[m.raddr];
				st_next.rvalid = st_reg.valid[m.raddr];
			end else begin
				st_next.rdata = '0;
				st_next.rvalid = 1'b0;
			end
		end
	end

	// the data array has no reset; only the valid flags mark a blank location
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg.mem <= st_next.mem;
			st_reg.valid <= '0;
			st_reg.rdata <= '0;
			st_reg.rvalid <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign m.rdata = st_reg.rdata;
	assign m.rvalid = st_reg.rvalid;
endmodule : spsb_nv_store
`default_nettype wire

// ==== verilog/spsb_status_core.sv ====
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - status byte is driven to the controller while serial poll enable is active
// - byte layout: bit3 breakpoint, bit4 ready, bit5 error, bit6 service request
// - service request bit set together with srq line asserted
// - commands are ignored while a service request is pending
// - error and service bits clear when a serial poll transaction completes
// - ready clears when a command arrives, sets when execution finishes
// - trigger output rises when ready falls and falls when ready rises
// - every status bit is active high
// - modules added or re-addressed after saving location 0 are not programmed when it is recalled by command
// - power-up recalls location 0, blank after every reset; a blank location opens all relays at power-up, recall by command leaves them as they are
// - save without location stores into 100; locations 0 to 100 accepted
module spsb_status_core
	import spsb_pkg::*;
#(
	parameter int MODS = 4,
	parameter int BPM = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic spe_active,
	input wire logic spe_done,
	input wire logic cmd_valid,
	input wire spsb_cmd_t cmd_op,
	input wire logic cmd_has_loc,
	input wire logic [6:0] cmd_loc,
	output logic cmd_accept,
	input wire logic exec_done,
	input wire logic prog_error,
	input wire logic [7:0] prog_error_code,
	input wire logic scan_breakpoint,
	input wire logic [MODS-1:0] modules_present,
	input wire logic [MODS*BPM-1:0] relay_state_in,
	output logic [7:0] status_byte,
	output logic status_drive_n,
	output logic srq_o,
	output logic srq_oe_n,
	output logic trig_out,
	output logic [7:0] error_code,
	output logic [MODS*BPM-1:0] relay_state_out,
	output logic [MODS-1:0] relay_load_mask,
	output logic relay_load
);
	localparam int RW = MODS * BPM;
	localparam int WW = MODS + RW;

	if (MODS < 1 || BPM < 1) begin : g_chk
		$error("spsb_status_core: module count and relays per module must be positive");
	end

	typedef struct packed {
		spsb_state_t fsm;
		logic brk;
		logic rdy;
		logic err;
		logic srq;
		logic [7:0] stb;
		logic drive_n;
		logic trig;
		logic [7:0] ecode;
		logic [RW-1:0] relay;
		logic [MODS-1:0] lmask;
		logic load;
	} spsb_core_t;

	spsb_core_t st_reg;
	spsb_core_t st_next;

	spsb_mem_if #(.AW(LOC_WIDTH), .W(WW)) nv();

	spsb_nv_store #(
		.DEPTH(NV_DEPTH),
		.AW(LOC_WIDTH),
		.W(WW)
	) u_store (
		.clk(clk),
		.rstn(rstn),
		.m(nv.store)
	);

	////////////////////////////////////////////////////////////////////////
	// command intake

	logic [6:0] loc;
	logic set_err;
	logic [7:0] set_code;

	assign loc = cmd_has_loc ? cmd_loc : LOC_DEFAULT;
	assign cmd_accept = cmd_valid && (st_reg.fsm == ST_IDLE) && !st_reg.srq;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;
		st_next.load = 1'b0;
		st_next.brk = scan_breakpoint;
		nv.we = 1'b0;
		nv.re = 1'b0;
		nv.waddr = loc;
		nv.raddr = loc;
		nv.wdata = {modules_present, relay_state_in};
		set_err = prog_error;
		set_code = prog_error_code;
		case (st_reg.fsm)
			ST_BOOT_RD: begin
				nv.re = 1'b1;
				nv.raddr = LOC_POWERUP;
				st_next.fsm = ST_BOOT_WT;
			end
			ST_BOOT_WT: begin
				if (nv.rvalid) begin
					st_next.relay = nv.rdata[RW-1:0];
					st_next.lmask = nv.rdata[WW-1:RW] & modules_present;
				end else begin
					st_next.relay = '0;
					st_next.lmask = modules_present;
				end
				st_next.load = 1'b1;
				st_next.rdy = 1'b1;
				st_next.fsm = ST_IDLE;
			end
			ST_IDLE: begin
				if (cmd_accept) begin
					st_next.rdy = 1'b0;
					case (cmd_op)
						CMD_SAVE: begin
							if (loc > LOC_MAX) begin
								set_err = 1'b1;
								set_code = ERR_BAD_LOC;
							end else begin
								nv.we = 1'b1;
							end
							st_next.fsm = ST_FINISH;
						end
						CMD_RECALL: begin
							if (loc > LOC_MAX) begin
								set_err = 1'b1;
								set_code = ERR_BAD_LOC;
								st_next.fsm = ST_FINISH;
							end else begin
								nv.re = 1'b1;
								st_next.fsm = ST_RCL_WT;
							end
						end
						default: begin
							st_next.fsm = ST_EXEC;
						end
					endcase
				end
			end
			ST_EXEC: begin
				if (exec_done) begin
					st_next.rdy = 1'b1;
					st_next.fsm = ST_IDLE;
				end
			end
			ST_RCL_WT: begin
				// a blank location leaves the relays as they are
				if (nv.rvalid) begin
					st_next.relay = nv.rdata[RW-1:0];
					st_next.lmask = nv.rdata[WW-1:RW] & modules_present;
					st_next.load = 1'b1;
				end
				st_next.rdy = 1'b1;
				st_next.fsm = ST_IDLE;
			end
			ST_FINISH: begin
				st_next.rdy = 1'b1;
				st_next.fsm = ST_IDLE;
			end
			default: begin
				st_next.fsm = ST_BOOT_RD;
			end
		endcase

		if (spe_done) begin
			st_next.err = 1'b0;
			st_next.srq = 1'b0;
		end
		// error raises request; a set in the clearing cycle wins
		if (set_err) begin
			st_next.err = 1'b1;
			st_next.srq = 1'b1;
			st_next.ecode = set_code;
		end

		st_next.trig = ~st_next.rdy;
		st_next.stb = spsb_build_stb(st_next.brk, st_next.rdy, st_next.err, st_next.srq);
		st_next.drive_n = ~spe_active;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg.fsm <= ST_BOOT_RD;
			st_reg.brk <= 1'b0;
			st_reg.rdy <= RST_READY;
			st_reg.err <= 1'b0;
			st_reg.srq <= 1'b0;
			st_reg.stb <= 8'h00;
			st_reg.drive_n <= RST_DRIVE_N;
			st_reg.trig <= RST_TRIG;
			st_reg.ecode <= ERR_NONE;
			st_reg.relay <= '0;
			st_reg.lmask <= '0;
			st_reg.load <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign status_byte = st_reg.stb;
	assign status_drive_n = st_reg.drive_n;
	// open-drain srq follows the service bit
	assign srq_o = 1'b0;
	assign srq_oe_n = ~st_reg.srq;
	assign trig_out = st_reg.trig;
	assign error_code = st_reg.ecode;
	assign relay_state_out = st_reg.relay;
	assign relay_load_mask = st_reg.lmask;
	assign relay_load = st_reg.load;
endmodule : spsb_status_core
`default_nettype wire
